// File: design/pcs_program_counter.sv
// program counter sequencer: next-address choice, return stack, table read
// assumes one op per instruction cycle from decode, stepEn marking cycles
//
// Contract
// - increment by one unless something loads
// - program counter is ten bits wide
// - reset forces counter to address zero
// - direct jump loads operand address
// - indirect jump copies pointer bits nine..zero
// - direct call pushes then loads operand
// - indirect call pushes then loads pointer
// - stack holds five ten-bit entries
// - all three returns reload popped address
// - table read pushes, addresses pointer, captures
// - table read pops saved counter afterward
// - table read occupies one stack level
// - true skip turns next instruction to nop
// - skip costs same cycles either way
// - interrupt pushes then loads source vector
// - small variant has 768 words
// - small variant beyond 300H reads all ones
// - counter does not wrap after 02FFH
// - vectors fixed at 0000H to 0003H
// - operands eleven bits, top bit zero
// - table read fills four latch nibbles
// - table read takes two instruction cycles
`timescale 1ns/100ps
`include "pcs_regs.svh"
module pcs_program_counter #(
    parameter int SMALL_MEM = 1            // 1: 768-word variant
) (
    input  wire logic                          clk,          // 40 MHz
    input  wire logic                          sys_rst,      // sync high
    input  wire logic                          stepEn,       // cycle edge
    input  wire pcs_pkg::pcs_op_e              opCode,       // decoded op
    input  wire logic [`PCS_OPERAND_WIDTH-1:0] operand,      // jump target
    input  wire logic [`PCS_PC_WIDTH-1:0]      jumpPointer,  // pointer reg
    input  wire logic                          skipTrue,     // skip met
    input  wire logic                          irqTake,      // irq accepted
    input  wire pcs_pkg::pcs_irq_e             irqSource,    // irq source
    input  wire logic [`PCS_WORD_WIDTH-1:0]    romWord,      // rom data
    output logic [`PCS_PC_WIDTH-1:0]           programCount, // current pc
    output logic [`PCS_PC_WIDTH-1:0]           romAddr,      // fetch addr
    output logic [`PCS_WORD_WIDTH-1:0]         fetchWord,    // fetched word
    output logic                               nopSlot,      // run as nop
    output logic [`PCS_WORD_WIDTH-1:0]         tableLatch,   // table data
    output logic                               tableBusy,    // 2nd cycle
    output logic [`PCS_SP_WIDTH-1:0]           stackPtr      // stack level
);
    import pcs_pkg::*;

    localparam int DEPTH = `PCS_STACK_DEPTH;

    logic [`PCS_PC_WIDTH-1:0]   pc_reg,    pc_next;
    logic [`PCS_PC_WIDTH-1:0]   addr_reg,  addr_next;
    logic [`PCS_PC_WIDTH-1:0]   stack_reg [DEPTH];
    logic [`PCS_PC_WIDTH-1:0]   stack_next[DEPTH];
    logic [`PCS_SP_WIDTH-1:0]   sp_reg,    sp_next;
    logic                       skip_reg,  skip_next;
    logic                       tbl_reg,   tbl_next;
    logic [`PCS_WORD_WIDTH-1:0] latch_reg, latch_next;
    logic [`PCS_WORD_WIDTH-1:0] word_reg,  word_next;
    logic [`PCS_PC_WIDTH-1:0]   seqAddr;
    logic [`PCS_SP_WIDTH-1:0]   spTop;
    logic                       opLive;

    // wrap the pointer inside the five entries
    function automatic logic [`PCS_SP_WIDTH-1:0] spStep(
        input logic [`PCS_SP_WIDTH-1:0] sp,
        input logic                     up
    );
        if (up) begin
            spStep = (sp == `PCS_SP_WIDTH'(DEPTH - 1)) ? '0 : sp + 1'b1;
        end else begin
            spStep = (sp == '0) ? `PCS_SP_WIDTH'(DEPTH - 1) : sp - 1'b1;
        end
    endfunction

    // small part: unimplemented space reads as all ones
    function automatic logic [`PCS_WORD_WIDTH-1:0] romView(
        input logic [`PCS_PC_WIDTH-1:0]   a,
        input logic [`PCS_WORD_WIDTH-1:0] w
    );
        if (SMALL_MEM != 0 && a >= `PCS_SMALL_LIMIT) begin
            romView = `PCS_BLANK_WORD;
        end else begin
            romView = w;
        end
    endfunction

    assign seqAddr = pc_reg + 1'b1;    // no wrap at 02FFH
    assign spTop   = spStep(sp_reg, 1'b0);

    always_comb begin
        pc_next    = pc_reg;
        addr_next  = addr_reg;
        stack_next = stack_reg;
        sp_next    = sp_reg;
        skip_next  = skip_reg;
        tbl_next   = tbl_reg;
        latch_next = latch_reg;
        word_next  = romView(addr_reg, romWord);
        if (sys_rst) begin
            pc_next   = `PCS_RESET_PC;
            addr_next = `PCS_RESET_PC;
            sp_next   = '0;
            skip_next = 1'b0;
            tbl_next  = 1'b0;
        end else if (stepEn && tbl_reg) begin
            // second cycle: capture word, pop the saved counter
            latch_next = romView(addr_reg, romWord);
            pc_next    = stack_reg[spTop];
            addr_next  = stack_reg[spTop];
            sp_next    = spTop;
            tbl_next   = 1'b0;
        end else if (stepEn) begin
            skip_next = 1'b0;
            pc_next   = seqAddr;
            if (irqTake) begin
                stack_next[sp_reg] = seqAddr;
                sp_next = spStep(sp_reg, 1'b1);
                unique case (irqSource)
                    PCS_IRQ_SERIAL:   pc_next = `PCS_VEC_SERIAL;
                    PCS_IRQ_TIMER:    pc_next = `PCS_VEC_TIMER;
                    PCS_IRQ_EXTERNAL: pc_next = `PCS_VEC_EXTERNAL;
                    default:          pc_next = `PCS_RESET_PC;
                endcase
            end else if (skip_reg) begin
                pc_next = seqAddr;
            end else begin
                unique case (opCode)
                    PCS_OP_JUMP_DIRECT:
                        pc_next = operand[`PCS_PC_WIDTH-1:0];
                    PCS_OP_JUMP_POINTER:
                        pc_next = jumpPointer;
                    PCS_OP_CALL_DIRECT: begin
                        stack_next[sp_reg] = seqAddr;
                        sp_next = spStep(sp_reg, 1'b1);
                        pc_next = operand[`PCS_PC_WIDTH-1:0];
                    end
                    PCS_OP_CALL_POINTER: begin
                        stack_next[sp_reg] = seqAddr;
                        sp_next = spStep(sp_reg, 1'b1);
                        pc_next = jumpPointer;
                    end
                    PCS_OP_SUBROUTINE_EXIT,
                    PCS_OP_INTERRUPT_EXIT: begin
                        pc_next = stack_reg[spTop];
                        sp_next = spTop;
                    end
                    PCS_OP_EXIT_WITH_SKIP: begin
                        pc_next   = stack_reg[spTop];
                        sp_next   = spTop;
                        skip_next = 1'b1;
                    end
                    PCS_OP_TABLE_FETCH: begin
                        stack_next[sp_reg] = seqAddr;
                        sp_next = spStep(sp_reg, 1'b1);
                        pc_next = jumpPointer;
                        tbl_next = 1'b1;
                    end
                    default: begin
                        pc_next   = seqAddr;
                        skip_next = skipTrue;
                    end
                endcase
            end
            addr_next = pc_next;
        end
    end

    always_ff @(posedge clk) begin
        pc_reg    <= pc_next;
        addr_reg  <= addr_next;
        stack_reg <= stack_next;
        sp_reg    <= sp_next;
        skip_reg  <= skip_next;
        tbl_reg   <= tbl_next;
        latch_reg <= latch_next;
        word_reg  <= word_next;
    end

    always_ff @(posedge clk) begin
        programCount <= pc_next;
        romAddr      <= addr_next;
        fetchWord    <= word_next;
        nopSlot      <= skip_next;
        tableLatch   <= latch_next;
        tableBusy    <= tbl_next;
        stackPtr     <= sp_next;
    end

    // op that no skip, irq or table cycle masks
    assign opLive = stepEn && !tbl_reg && !irqTake && !skip_reg;

    a_reset_zero: assert property (@(posedge clk)
        sys_rst |=> programCount == `PCS_RESET_PC
        && romAddr == `PCS_RESET_PC && stackPtr == '0
        && !nopSlot && !tableBusy)
        else $error("pc not zero after reset");
    a_step_inc: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && !irqTake && opCode == PCS_OP_NONE
        |=> programCount == $past(pc_reg) + 1'b1)
        else $error("pc did not increment");
    a_no_wrap: assert property (
        @(posedge clk) disable iff (sys_rst)
        opLive && opCode == PCS_OP_NONE && seqAddr == `PCS_SMALL_LIMIT
        |=> programCount == `PCS_SMALL_LIMIT)
        else $error("pc wrapped after last word");
    a_jump_direct: assert property (
        @(posedge clk) disable iff (sys_rst)
        opLive && opCode == PCS_OP_JUMP_DIRECT
        |=> programCount == $past(operand[`PCS_PC_WIDTH-1:0]))
        else $error("direct jump target wrong");
    a_jump_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && !irqTake && !skip_reg
        && opCode == PCS_OP_JUMP_POINTER
        |=> programCount == $past(jumpPointer))
        else $error("indirect jump target wrong");
    a_call_push: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && !irqTake && !skip_reg
        && opCode == PCS_OP_CALL_DIRECT
        |=> stackPtr == spStep($past(sp_reg), 1'b1)
        && programCount == $past(operand[`PCS_PC_WIDTH-1:0]))
        else $error("direct call wrong");
    a_call_pointer: assert property (
        @(posedge clk) disable iff (sys_rst)
        opLive && opCode == PCS_OP_CALL_POINTER
        |=> programCount == $past(jumpPointer)
        && stack_reg[$past(sp_reg)] == $past(seqAddr))
        else $error("indirect call wrong");
    a_return_pop: assert property (
        @(posedge clk) disable iff (sys_rst)
        opLive && (opCode == PCS_OP_SUBROUTINE_EXIT
        || opCode == PCS_OP_EXIT_WITH_SKIP
        || opCode == PCS_OP_INTERRUPT_EXIT)
        |=> programCount == $past(stack_reg[spTop])
        && sp_reg == $past(spTop))
        else $error("return did not pop");
    a_irq_vector: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && irqTake && irqSource == PCS_IRQ_TIMER
        |=> programCount == `PCS_VEC_TIMER)
        else $error("timer vector wrong");
    a_irq_serial: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && irqTake && irqSource == PCS_IRQ_SERIAL
        |=> programCount == `PCS_VEC_SERIAL)
        else $error("serial vector wrong");
    a_irq_external: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && irqTake && irqSource == PCS_IRQ_EXTERNAL
        |=> programCount == `PCS_VEC_EXTERNAL)
        else $error("external vector wrong");
    a_irq_push: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && irqTake
        |=> stack_reg[$past(sp_reg)] == $past(seqAddr)
        && stackPtr == spStep($past(sp_reg), 1'b1))
        else $error("interrupt push wrong");
    a_table_push: assert property (
        @(posedge clk) disable iff (sys_rst)
        opLive && opCode == PCS_OP_TABLE_FETCH
        |=> stack_reg[$past(sp_reg)] == $past(seqAddr)
        && stackPtr == spStep($past(sp_reg), 1'b1))
        else $error("table read did not push");
    a_table_two: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && !irqTake && !skip_reg
        && opCode == PCS_OP_TABLE_FETCH
        |=> tableBusy && romAddr == $past(jumpPointer))
        else $error("table read first cycle wrong");
    a_table_pop: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && tbl_reg |=> !tableBusy
        && programCount == $past(stack_reg[spTop]))
        else $error("table read did not restore pc");
    a_latch_word: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && tbl_reg && addr_reg < `PCS_SMALL_LIMIT
        |=> tableLatch == $past(romWord))
        else $error("table word not latched");
    a_blank_rom: assert property (
        @(posedge clk) disable iff (sys_rst)
        SMALL_MEM != 0 && addr_reg >= `PCS_SMALL_LIMIT
        |=> fetchWord == `PCS_BLANK_WORD)
        else $error("blank space not all ones");
    a_skip_flag: assert property (
        @(posedge clk) disable iff (sys_rst)
        opLive && opCode == PCS_OP_NONE
        |=> nopSlot == $past(skipTrue) && !tableBusy)
        else $error("skip flag wrong");
    a_skip_nop: assert property (
        @(posedge clk) disable iff (sys_rst)
        stepEn && !tbl_reg && !irqTake && skip_reg
        |=> programCount == $past(pc_reg) + 1'b1)
        else $error("skipped slot changed flow");

    c_call_ret: cover property (@(posedge clk)
        opCode == PCS_OP_CALL_DIRECT && stepEn ##[1:20]
        opCode == PCS_OP_SUBROUTINE_EXIT && stepEn);
    c_table: cover property (@(posedge clk) tbl_reg && stepEn);
    c_irq: cover property (@(posedge clk) irqTake && stepEn);
    c_skip: cover property (@(posedge clk) skip_reg && stepEn);
    c_exit_skip: cover property (@(posedge clk)
        opLive && opCode == PCS_OP_EXIT_WITH_SKIP);
endmodule // pcs_program_counter

// File: design/pcs_regs.svh
// constants for the program counter sequencer
// assumes inclusion by the package and the design module only
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
`define PCS_PC_WIDTH      10
`define PCS_STACK_DEPTH   5
`define PCS_SP_WIDTH      3
`define PCS_OPERAND_WIDTH 11
`define PCS_WORD_WIDTH    16
`define PCS_RESET_PC      10'h000
`define PCS_VEC_SERIAL    10'h001
`define PCS_VEC_TIMER     10'h002
`define PCS_VEC_EXTERNAL  10'h003
`define PCS_SMALL_LIMIT   10'h300
`define PCS_BLANK_WORD    16'hFFFF
`endif

// File: design/pcs_pkg.sv
// types shared by the program counter sequencer
// assumes the constants header sits beside it
`include "pcs_regs.svh"
package pcs_pkg;
    typedef enum logic [3:0] {
        PCS_OP_NONE,
        PCS_OP_JUMP_DIRECT,
        PCS_OP_JUMP_POINTER,
        PCS_OP_CALL_DIRECT,
        PCS_OP_CALL_POINTER,
        PCS_OP_SUBROUTINE_EXIT,
        PCS_OP_EXIT_WITH_SKIP,
        PCS_OP_INTERRUPT_EXIT,
        PCS_OP_TABLE_FETCH
    } pcs_op_e;
    typedef enum logic [1:0] {
        PCS_IRQ_SERIAL,
        PCS_IRQ_TIMER,
        PCS_IRQ_EXTERNAL
    } pcs_irq_e;
    typedef logic [`PCS_PC_WIDTH-1:0] pcs_addr_t;
endpackage : pcs_pkg

// File: test/pcs_rom_model.sv
// program memory model answering the sequencer fetch port
// assumes a combinational read of any 10-bit address
`timescale 1ns/100ps
module pcs_rom_model (
    input  wire logic [9:0]  romAddr, // fetch address
    output logic      [15:0] romWord  // word at address
);
    // pattern differs per address so a stale read shows
    assign romWord = {~romAddr[5:0], romAddr};
endmodule // pcs_rom_model

// File: test/pcs_program_counter_tb.sv
// self-checking bench for the program counter sequencer
// assumes the rom model answers any address combinationally
`timescale 1ns/100ps
module pcs_program_counter_tb;
    import pcs_pkg::*;
    logic        clk = 0;
    logic        sysRst = 1;
    logic        stepEn = 0;
    pcs_op_e     opCode = PCS_OP_NONE;
    logic [10:0] operand = '0;
    logic [9:0]  jumpPointer = '0;
    logic        skipTrue = 0;
    logic        irqTake = 0;
    pcs_irq_e    irqSource = PCS_IRQ_SERIAL;
    logic [15:0] romWord, fetchWord, tableLatch;
    logic [9:0]  programCount, romAddr;
    logic        nopSlot, tableBusy;
    logic [2:0]  stackPtr;
    int          numErrors = 0;
    int          nChecks = 0;
    int          mPc, mSp, mNop, mBusy, mTbl, mLatch = -1;
    int          stk[5];

    always #12.5 clk = ~clk;

    pcs_program_counter i_pcs_program_counter (
        .clk(clk), .sys_rst(sysRst), .stepEn(stepEn), .opCode(opCode),
        .operand(operand), .jumpPointer(jumpPointer), .skipTrue(skipTrue),
        .irqTake(irqTake), .irqSource(irqSource), .romWord(romWord),
        .programCount(programCount), .romAddr(romAddr),
        .fetchWord(fetchWord), .nopSlot(nopSlot), .tableLatch(tableLatch),
        .tableBusy(tableBusy), .stackPtr(stackPtr));
    pcs_rom_model i_pcs_rom_model (.romAddr(romAddr), .romWord(romWord));

    task automatic results();
        if (numErrors == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic int rom(input int a);
        return ((~a & 'h3f) << 10) | a;
    endfunction

    task automatic compare();
        check(16'(programCount), 16'(mPc));
        check(16'(romAddr), 16'(mPc));
        check(16'(stackPtr), 16'(mSp));
        check(16'(nopSlot), 16'(mNop));
        check(16'(tableBusy), 16'(mBusy));
        if (mLatch >= 0) check(tableLatch, 16'(mLatch));
        check(fetchWord, 16'(mPc >= 'h300 ? 'hffff : rom(mPc)));
    endtask

    task automatic doReset();
        @(negedge clk);
        sysRst = 1;
        repeat (2) @(negedge clk);
        sysRst = 0;
        mPc = 0;
        mSp = 0;
        mNop = 0;
        mBusy = 0;
        @(negedge clk);
        compare();
    endtask

    task automatic step(input pcs_op_e op, input int arg, input logic skp,
                        input logic irq, input pcs_irq_e src);
        int nxt;
        int jp;
        jp = arg % 768;
        @(negedge clk);
        opCode = op;
        operand = 11'(jp);
        jumpPointer = 10'(jp);
        skipTrue = skp & !mBusy & !mNop;
        irqTake = irq & !mBusy;
        irqSource = src;
        stepEn = 1;
        @(negedge clk);
        stepEn = 0;
        nxt = (mPc + 1) & 'h3ff;
        if (mBusy) begin
            mLatch = rom(mTbl);
            mSp = (mSp + 4) % 5;
            mPc = stk[mSp];
            mBusy = 0;
        end else if (irqTake) begin
            stk[mSp] = nxt;
            mSp = (mSp + 1) % 5;
            mPc = int'(src) + 1;
            mNop = 0;
        end else if (mNop) begin
            mPc = nxt;
            mNop = 0;
        end else case (op)
            PCS_OP_JUMP_DIRECT: mPc = jp;
            PCS_OP_JUMP_POINTER: mPc = jp;
            PCS_OP_CALL_DIRECT, PCS_OP_CALL_POINTER, PCS_OP_TABLE_FETCH: begin
                stk[mSp] = nxt;
                mSp = (mSp + 1) % 5;
                mPc = jp;
                mBusy = (op == PCS_OP_TABLE_FETCH);
                mTbl = jp;
            end
            PCS_OP_SUBROUTINE_EXIT, PCS_OP_EXIT_WITH_SKIP,
            PCS_OP_INTERRUPT_EXIT: begin
                mSp = (mSp + 4) % 5;
                mPc = stk[mSp];
                mNop = (op == PCS_OP_EXIT_WITH_SKIP);
            end
            default: begin
                mPc = nxt;
                mNop = skp;
            end
        endcase
        @(negedge clk);
        compare();
    endtask

    initial begin
        #250000;
        numErrors++;
        results();
    end

    initial begin
        void'($urandom(32'h3db9_f1f2));
        doReset();
        for (int i = 0; i < 5; i++)
            step(PCS_OP_CALL_DIRECT, 'h100 + i * 7, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_JUMP_DIRECT, 'h2ff, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_NONE, 0, 0, 0, PCS_IRQ_SERIAL);
        for (int s = 0; s < 3; s++) begin
            step(PCS_OP_NONE, 0, 0, 1, pcs_irq_e'(s));
            step(PCS_OP_INTERRUPT_EXIT, 0, 0, 0, PCS_IRQ_SERIAL);
        end
        step(PCS_OP_TABLE_FETCH, 'h155, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_CALL_DIRECT, 'h3a0, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_TABLE_FETCH, 'h2fe, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_NONE, 0, 1, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_JUMP_DIRECT, 'h80, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_EXIT_WITH_SKIP, 0, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_NONE, 0, 0, 0, PCS_IRQ_SERIAL);
        step(PCS_OP_JUMP_POINTER, 'h2aa, 0, 0, PCS_IRQ_SERIAL);
        for (int k = 0; k < 2; k++) begin
            repeat (300)
                step(pcs_op_e'($urandom % 9), $urandom & 'h3ff, $urandom % 2,
                     ($urandom % 8) == 0, pcs_irq_e'($urandom % 3));
            doReset();
        end
        results();
    end
endmodule // pcs_program_counter_tb
